// *** core/wrc_cfg.svh ***
`ifndef WRC_CFG_SVH
`define WRC_CFG_SVH
// What this block does
// - watchdog on after reset; disable until end-of-init
// - overflow raises internal reset, drives reset-out low
// - flags record last power-on or synchronous reset cause
// - end-of-init clears all reset-source flags
// - 16-bit counter, clock divided by 2 or 128
// - service reloads high byte from reload value
// - timeout 5.12us/ff div2, 83.9ms/00 div128
// - five reset sources distinguished
// - long hardware flag past long limit
// - short hardware flag on every synchronous hardware reset past filter
// - async entry forces default state, reset-out low
// - mode pin low inhibits bidir drive on sw/wdt
// - internal boot holds reset until flash ready
// - external boot releases after 3 to 8 half-clocks
// - early flash reads return ffff then 009b
// - mode pin low during reset means asynchronous
// - sample filtered input after 1024+16+8 half-clocks
// - bidir enable bit 3, cleared by reset

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define WRC_CLK_NS        10
`define WRC_FILTER_NS     500
`define WRC_FILTER_CYC    ((`WRC_FILTER_NS + `WRC_CLK_NS - 1) / `WRC_CLK_NS)
`define WRC_SEQ_TCL       1024
`define WRC_SEQ_CYC       (`WRC_SEQ_TCL / 2)
`define WRC_SETTLE_TCL    16
`define WRC_SAMPLE_TCL    8
`define WRC_SAMPLE_CYC    (`WRC_SAMPLE_TCL / 2)
`define WRC_LONG_CYC      ((1032 + 12) / 2 + `WRC_FILTER_CYC)
`define WRC_EXT_REL_CYC   2
`define WRC_FLASH_NS      1000000
`define WRC_FLASH_CYC     (`WRC_FLASH_NS / `WRC_CLK_NS)
`define WRC_FLASH_EARLY   16'hffff
`define WRC_FLASH_LATE    16'h009b
`define WRC_DIV_SLOW      128
`define WRC_DIV_FAST      2
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define WRC_BIDIR_BIT     3
`define WRC_SYSCFG_RST    16'h0000
`endif

// *** core/wrc_pkg.sv ***
package wrc_pkg;
    // reset-source flags, read as the watchdog control status
    typedef struct packed {
        logic pwr_on;     // power-on
        logic long_hw;    // long hardware
        logic short_hw;   // short hardware
        logic wdt;        // watchdog overflow
        logic sw;         // software reset
    } wrc_flags_s;
    // software-side commands, one-cycle pulses
    typedef struct packed {
        logic service;    // watchdog service
        logic disable_wd; // watchdog disable
        logic end_init;   // end-of-init instruction
        logic sw_reset;   // software reset instruction
    } wrc_cmd_s;
    typedef enum logic [2:0] {
        WRC_RUN, WRC_FILT, WRC_SEQ, WRC_SAMPLE, WRC_HOLD, WRC_ASYNC, WRC_REL
    } wrc_state_e;
endpackage

// *** core/wrc_rst_filter.sv ***
`timescale 1ns/1ns
`include "wrc_cfg.svh"
module wrc_rst_filter #(
    parameter int FILT_CYC = `WRC_FILTER_CYC
) (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic reset_in_n,     // raw pin level
    output logic      filtered_n      // filtered reset-in level
);
    import wrc_pkg::*;
    logic [7:0] cnt_reg;  // stable-level counter
    // ----------------------------------------------------------------
    // level changes only after FILT_CYC stable cycles
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg    <= 8'h00;
            filtered_n <= 1'b0;
        end else if (clk_en) begin
            if (reset_in_n == filtered_n) begin
                cnt_reg <= 8'h00;
            end else if (cnt_reg == 8'(FILT_CYC - 1)) begin
                cnt_reg    <= 8'h00;
                filtered_n <= reset_in_n;
            end else begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end
endmodule

// *** core/wrc_top.sv ***
`timescale 1ns/1ns
`include "wrc_cfg.svh"
module wrc_top #(
    parameter int FLASH_CYC = `WRC_FLASH_CYC,  // flash init time
    parameter int FILT_CYC  = `WRC_FILTER_CYC  // input filter length
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    input  wire logic             reset_in_n,     // reset-in pin level
    output logic                  reset_in_o,     // reset-in pin drive value
    output logic                  reset_in_oe,    // reset-in pin drive enable
    input  wire logic             reset_mode_pin, // high: synchronous
    input  wire logic             ext_access_n,   // low: external boot
    output logic                  reset_out_n,    // reset-out pin
    output logic                  int_reset,      // internal reset
    output logic                  async_state,    // async default state
    input  wire wrc_pkg::wrc_cmd_s cmd,           // software commands
    input  wire logic             prescale_sel,   // watchdog prescale select
    input  wire logic [7:0]       reload_value,   // watchdog reload value
    input  wire logic             syscfg_we,      // system config write
    input  wire logic [15:0]      syscfg_wdata,   // system config data
    output logic [15:0]           syscfg,         // system config register
    output wrc_pkg::wrc_flags_s   flags,          // reset-source flags
    output logic                  wdt_enabled,    // watchdog running
    output logic                  init_done,      // end-of-init executed
    output logic [15:0]           wdt_count,      // watchdog count
    output logic [15:0]           flash_word,     // early flash read value
    output logic                  flash_ready     // flash init finished
);
    import wrc_pkg::*;
    wrc_state_e state_reg;       // sequence state
    logic [19:0] cnt_reg;        // sequence counter
    logic        filt_n;         // filtered reset-in
    logic        overflow;       // watchdog overflow pulse
    logic        src_wdt_reg;    // sequence caused by watchdog
    logic        src_sw_reg;     // sequence caused by software
    logic        drive_reg;      // bidir drive of reset-in
    logic        hw_low;         // hardware reset request
    logic        sw_evt;         // software/watchdog reset event
    logic        async_req;      // asynchronous entry
    logic [19:0] flash_cnt_reg;  // flash init counter
    // ----------------------------------------------------------------
    // submodules
    // ----------------------------------------------------------------
    wrc_rst_filter #(.FILT_CYC(FILT_CYC)) u_filt (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .reset_in_n(reset_in_n),
        .filtered_n(filt_n)
    );
    wrc_wdt_counter #(.WIDTH(16)) u_wdt (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .clk_en      (clk_en),
        .rst_int     (int_reset),
        .run         (wdt_enabled),
        .prescale_sel(prescale_sel),
        .reload      (reload_value),
        .service     (cmd.service),
        .count       (wdt_count),
        .overflow    (overflow)
    );
    // ----------------------------------------------------------------
    // event decode
    // ----------------------------------------------------------------
    assign hw_low    = !filt_n && !drive_reg;
    assign sw_evt    = (state_reg == WRC_RUN) && (overflow || cmd.sw_reset);
    assign async_req = !filt_n && !reset_mode_pin && !drive_reg;
    // ----------------------------------------------------------------
    // reset sequence
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= WRC_ASYNC;
            cnt_reg   <= 20'h00000;
        end else if (clk_en) begin
            cnt_reg <= cnt_reg + 20'h00001;
            if (async_req && state_reg != WRC_ASYNC) begin
                state_reg <= WRC_ASYNC;
                cnt_reg   <= 20'h00000;
            end else begin
                case (state_reg)
                    WRC_RUN: begin
                        cnt_reg <= 20'h00000;
                        if (sw_evt || hw_low) begin
                            state_reg <= WRC_SEQ;
                        end
                    end
                    WRC_SEQ: begin
                        if (cnt_reg == 20'(`WRC_SEQ_CYC + `WRC_SETTLE_TCL / 2 - 1)) begin
                            state_reg <= WRC_SAMPLE;
                            cnt_reg   <= 20'h00000;
                        end
                    end
                    WRC_SAMPLE: begin
                        if (cnt_reg == 20'(`WRC_SAMPLE_CYC - 1)) begin
                            state_reg <= WRC_HOLD;
                            cnt_reg   <= 20'h00000;
                        end
                    end
                    WRC_HOLD: begin
                        if (filt_n) begin
                            state_reg <= WRC_REL;
                            cnt_reg   <= 20'h00000;
                        end
                    end
                    WRC_ASYNC: begin
                        cnt_reg <= 20'h00000;
                        if (filt_n) begin
                            state_reg <= WRC_REL;
                        end
                    end
                    WRC_REL: begin
                        if (ext_access_n ? flash_ready
                                         : cnt_reg >= 20'(`WRC_EXT_REL_CYC - 1)) begin
                            state_reg <= WRC_RUN;
                        end
                    end
                    default: state_reg <= WRC_ASYNC;
                endcase
            end
        end
    end
    assign int_reset   = (state_reg != WRC_RUN);
    assign async_state = (state_reg == WRC_ASYNC);
    assign reset_out_n = (state_reg == WRC_RUN);
    // ----------------------------------------------------------------
    // source memory and bidirectional drive
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            src_wdt_reg <= 1'b0;
            src_sw_reg  <= 1'b0;
            drive_reg   <= 1'b0;
        end else if (clk_en) begin
            if (sw_evt) begin
                src_wdt_reg <= overflow;
                src_sw_reg  <= !overflow;
                drive_reg   <= syscfg[`WRC_BIDIR_BIT] && reset_mode_pin;
            end else if (state_reg == WRC_RUN && hw_low) begin
                src_wdt_reg <= 1'b0;
                src_sw_reg  <= 1'b0;
            end
            if (state_reg == WRC_SAMPLE || state_reg == WRC_ASYNC) begin
                drive_reg <= 1'b0;
            end
        end
    end
    assign reset_in_o  = 1'b0;
    assign reset_in_oe = drive_reg;
    // ----------------------------------------------------------------
    // system config: bidir enable, cleared by every reset
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            syscfg <= `WRC_SYSCFG_RST;
        end else if (clk_en) begin
            if (int_reset) begin
                syscfg <= `WRC_SYSCFG_RST;
            end else if (syscfg_we) begin
                syscfg <= syscfg_wdata;
            end
        end
    end
    // ----------------------------------------------------------------
    // watchdog enable and end-of-init
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wdt_enabled <= 1'b1;
            init_done   <= 1'b0;
        end else if (clk_en) begin
            if (int_reset) begin
                wdt_enabled <= 1'b1;
                init_done   <= 1'b0;
            end else begin
                if (cmd.disable_wd && !init_done) begin
                    wdt_enabled <= 1'b0;
                end
                if (cmd.end_init) begin
                    init_done <= 1'b1;
                end
            end
        end
    end
    // ----------------------------------------------------------------
    // reset-source flags
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flags <= '{pwr_on: 1'b1, default: 1'b0};
        end else if (clk_en) begin
            if (!int_reset && cmd.end_init) begin
                flags <= '0;
            end
            if (state_reg == WRC_SAMPLE && cnt_reg == 20'(`WRC_SAMPLE_CYC - 1)) begin
                flags.pwr_on   <= 1'b0;        // only the last cause stands
                flags.wdt      <= src_wdt_reg;
                flags.sw       <= src_sw_reg;
                flags.short_hw <= !src_wdt_reg && !src_sw_reg;
                flags.long_hw  <= !src_wdt_reg && !src_sw_reg && !filt_n;
            end
        end
    end
    // ----------------------------------------------------------------
    // flash init timer and early read value
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flash_cnt_reg <= 20'h00000;
            flash_ready   <= 1'b0;
            flash_word    <= `WRC_FLASH_EARLY;
        end else if (clk_en) begin
            if (!filt_n && state_reg != WRC_RUN) begin
                flash_cnt_reg <= 20'h00000;
                flash_ready   <= 1'b0;
                flash_word    <= `WRC_FLASH_EARLY;
            end else if (!flash_ready) begin
                flash_cnt_reg <= flash_cnt_reg + 20'h00001;
                flash_word    <= `WRC_FLASH_LATE;
                if (flash_cnt_reg == 20'(FLASH_CYC - 1)) begin
                    flash_ready <= 1'b1;
                end
            end
        end
    end
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_disable_locked: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && init_done && !int_reset && wdt_enabled |=> wdt_enabled)
        else $error("watchdog disabled after end-of-init");
    a_ovf_reset: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && overflow && state_reg == WRC_RUN && !async_req |=> !reset_out_n)
        else $error("overflow did not reset");
    a_end_of_init_instruction_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && cmd.end_init && !int_reset |=> flags == '0)
        else $error("flags not cleared");
    a_async_entry: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && async_req |=> async_state && !reset_out_n)
        else $error("async reset not entered");
    a_ext_release: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && state_reg == WRC_REL && !ext_access_n && !async_req
        |=> ##[0:3] !int_reset)
        else $error("external boot release late");
    a_mode_inhibit: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && sw_evt && !reset_mode_pin |=> !reset_in_oe)
        else $error("bidir drive with mode pin low");
endmodule

// *** core/wrc_wdt_counter.sv ***
`timescale 1ns/1ns
`include "wrc_cfg.svh"
module wrc_wdt_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    input  wire logic       rst_int,      // block held in reset
    input  wire logic       run,          // counting allowed
    input  wire logic       prescale_sel, // 0: div 2, 1: div 128
    input  wire logic [7:0] reload,       // high-byte reload value
    input  wire logic       service,      // service pulse
    output logic [WIDTH-1:0] count,       // current count
    output logic            overflow      // carry out pulse
);
    import wrc_pkg::*;
    logic [6:0] pre_reg;   // prescaler
    logic       tick;      // counter advance
    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    assign tick = prescale_sel ? (pre_reg == 7'(`WRC_DIV_SLOW - 1)) : pre_reg[0];
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_reg <= 7'h00;
        end else if (clk_en) begin
            if (rst_int || service) begin
                pre_reg <= 7'h00;
            end else begin
                pre_reg <= pre_reg + 7'h01;
            end
        end
    end
    // ----------------------------------------------------------------
    // counter: counts up, carry out is overflow
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            count    <= '0;
            overflow <= 1'b0;
        end else if (clk_en) begin
            overflow <= 1'b0;
            if (rst_int) begin
                count <= '0;
            end else if (service) begin
                count <= {reload, 8'h00};
            end else if (run && tick) begin
                {overflow, count} <= {1'b0, count} + 17'h00001;
            end
        end
    end
    a_svc_reload: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && service && !rst_int |=> count == {$past(reload), 8'h00})
        else $error("service did not reload");
endmodule

// *** tb/wrc_far_side.sv ***
`timescale 1ns/1ns
module wrc_far_side (
    input  wire logic         mclk,
    input  wire logic         reset_in_o,
    input  wire logic         reset_in_oe,
    output logic              reset_in_n,
    output logic              reset_mode_pin,
    output wrc_pkg::wrc_cmd_s cmd,
    output logic              prescale_sel,
    output logic [7:0]        reload_value
);
    import wrc_pkg::*;
    // ----------------------------------------------------------------
    // reset-in wire
    // ----------------------------------------------------------------
    logic ext_low = 1'b1;  // held low through power-on
    // pull-up unless either side pulls low
    assign reset_in_n = !(ext_low || (reset_in_oe && !reset_in_o));
    // power-up levels
    initial begin
        reset_mode_pin = 1'b0;  // mode low at power-on
        cmd = '0;
        prescale_sel = 1'b0;
        reload_value = 8'h00;
    end
    // ----------------------------------------------------------------
    // software and reset circuit actions
    // ----------------------------------------------------------------
    // pin level for some cycles; level held until the next call
    task automatic pin(input logic lvl, input int cyc);
        @(negedge mclk);
        ext_low = !lvl;
        repeat (cyc) @(negedge mclk);
    endtask
    // synchronous or asynchronous handling
    task automatic set_mode(input logic m);
        @(negedge mclk);
        reset_mode_pin = m;
    endtask
    // one-cycle command pulse
    task automatic send(input wrc_cmd_s c);
        @(negedge mclk);
        cmd = c;
        @(negedge mclk);
        cmd = '0;
    endtask
    // control rewritten before each service
    task automatic service(input logic [7:0] rel, input logic pre);
        @(negedge mclk);
        reload_value = rel;
        prescale_sel = pre;
        send('{service: 1'b1, default: 1'b0});
    endtask
endmodule

// *** tb/wrc_top_bench.sv ***
`timescale 1ns/1ns
module wrc_top_bench;
    import wrc_pkg::*;
    // ----------------------------------------------------------------
    // clock, reset, wiring
    // ----------------------------------------------------------------
    localparam int FLASH = 20;  // shortened flash init
    localparam int FILT  = 3;   // shortened filter
    logic        mclk         = 1'b0;
    logic        sys_rst      = 1'b1;
    logic        clk_en       = 1'b1;  // freeze control
    logic        ext_access_n = 1'b1;  // internal boot first
    logic        syscfg_we    = 1'b0;
    logic [15:0] syscfg_wdata = 16'h0000;
    logic        reset_in_n, reset_in_o, reset_in_oe, reset_mode_pin;
    logic        reset_out_n, int_reset, async_state, prescale_sel;
    logic        wdt_enabled, init_done, flash_ready;
    logic [7:0]  reload_value;
    logic [15:0] syscfg, wdt_count, flash_word;
    wrc_cmd_s    cmd;
    wrc_flags_s  flags;
    int          num_errors = 0;
    int          checked    = 0;
    int          cycles     = 0;
    always #5 mclk = ~mclk;
    wrc_top #(.FLASH_CYC(FLASH), .FILT_CYC(FILT)) u_dut (
        .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .reset_in_n(reset_in_n),
        .reset_in_o(reset_in_o), .reset_in_oe(reset_in_oe), .reset_mode_pin(reset_mode_pin),
        .ext_access_n(ext_access_n), .reset_out_n(reset_out_n), .int_reset(int_reset),
        .async_state(async_state), .cmd(cmd), .prescale_sel(prescale_sel),
        .reload_value(reload_value), .syscfg_we(syscfg_we), .syscfg_wdata(syscfg_wdata),
        .syscfg(syscfg), .flags(flags), .wdt_enabled(wdt_enabled), .init_done(init_done),
        .wdt_count(wdt_count), .flash_word(flash_word), .flash_ready(flash_ready));
    wrc_far_side u_far (
        .mclk(mclk), .reset_in_o(reset_in_o), .reset_in_oe(reset_in_oe),
        .reset_in_n(reset_in_n), .reset_mode_pin(reset_mode_pin), .cmd(cmd),
        .prescale_sel(prescale_sel), .reload_value(reload_value));
    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // cycles until internal reset drops, bounded
    task automatic wait_run(output int n);
        for (n = 0; n < 3000 && int_reset !== 1'b0; n++) @(negedge mclk);
        if (n >= 3000) check("run_wait", 16'h0001, 16'h0000);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // power-on with internal boot, flash hold
    task automatic t_por();
        int n;
        logic late;
        late = 1'b0;
        check("por_flags", {11'h000, flags}, 16'h0010);
        check("por_wdt_on", wdt_enabled, 1'b1);
        check("por_syscfg", syscfg, 16'h0000);
        check("por_rst_out", reset_out_n, 1'b0);
        check("por_async", async_state, 1'b1);
        check("early_flash", flash_word, 16'hffff);
        u_far.pin(1'b1, 0);
        for (n = 0; n < 3000 && int_reset !== 1'b0; n++) begin
            @(negedge mclk);
            if (flash_word === 16'h009b) late = 1'b1;
        end
        check("flash_hold", n >= FLASH, 1'b1);
        check("flash_ready", flash_ready, 1'b1);
        check("late_flash", late, 1'b1);
        $display("done por");
    endtask
    // asynchronous reset, external boot release
    task automatic t_ext_boot();
        int n;
        ext_access_n = 1'b0;
        u_far.pin(1'b0, FILT + 4);
        check("async_entry", async_state, 1'b1);
        check("async_rst_out", reset_out_n, 1'b0);
        u_far.pin(1'b1, 0);
        wait_run(n);
        check("ext_release", n >= FILT && n <= FILT + 7, 1'b1);
        $display("done ext_boot");
    endtask
    // overflow after ff reload at divide by 2
    task automatic t_wdt();
        int n;
        u_far.service(8'hff, 1'b0);
        check("svc_load", wdt_count, 16'hff00);
        for (n = 0; n < 700 && reset_out_n !== 1'b0; n++) @(negedge mclk);
        check("timeout", n >= 505 && n <= 520, 1'b1);
        check("wdt_int", int_reset, 1'b1);
        wait_run(n);
        check("wdt_flag", {11'h000, flags}, 16'h0002);
        $display("done wdt");
    endtask
    // count rate for both prescale settings
    task automatic t_div();
        int e;
        for (int p = 0; p < 2; p++) begin
            e = (p == 1) ? 2 : 128;
            u_far.service(8'h00, p[0]);
            repeat (256) @(negedge mclk);
            check("prescale", wdt_count >= e - 1 && wdt_count <= e + 1, 1'b1);
        end
        // clock enable low: count must hold
        clk_en = 1'b0;
        e = wdt_count;
        repeat (200) @(negedge mclk);
        check("freeze", wdt_count, 16'(e));
        clk_en = 1'b1;
        $display("done div");
    endtask
    // disable window, software reset, end-of-init
    task automatic t_cmds();
        int n;
        u_far.send('{disable_wd: 1'b1, default: 1'b0});
        check("disable_early", wdt_enabled, 1'b0);
        u_far.send('{sw_reset: 1'b1, default: 1'b0});
        wait_run(n);
        check("sw_flag", {11'h000, flags}, 16'h0001);
        check("wdt_reenabled", wdt_enabled, 1'b1);
        u_far.send('{end_init: 1'b1, default: 1'b0});
        check("flags_cleared", {11'h000, flags}, 16'h0000);
        check("init_done", init_done, 1'b1);
        u_far.send('{disable_wd: 1'b1, default: 1'b0});
        check("disable_late", wdt_enabled, 1'b1);
        $display("done cmds");
    endtask
    // synchronous hardware pulse of given length
    task automatic t_hw(input int cyc, input logic lng);
        int n;
        u_far.send('{end_init: 1'b1, default: 1'b0});
        u_far.pin(1'b0, cyc);
        u_far.pin(1'b1, 0);
        wait_run(n);
        check("short_flag", flags.short_hw, 1'b1);
        check("long_flag", flags.long_hw, lng);
        $display("done hw %0d", cyc);
    endtask
    // mode pin falls during a synchronous reset
    task automatic t_async_mid();
        int n;
        u_far.pin(1'b0, 100);
        u_far.set_mode(1'b0);
        repeat (3) @(negedge mclk);
        check("late_async", async_state, 1'b1);
        u_far.pin(1'b1, 0);
        u_far.set_mode(1'b1);
        wait_run(n);
        $display("done async_mid");
    endtask
    // bidirectional drive on software reset, per mode level
    task automatic t_bidir(input logic m);
        int n;
        logic seen;
        seen = 1'b0;
        u_far.set_mode(m);
        syscfg_we = 1'b1;
        syscfg_wdata = 16'h0008;
        @(negedge mclk);
        syscfg_we = 1'b0;
        check("syscfg_wr", syscfg, 16'h0008);
        u_far.send('{sw_reset: 1'b1, default: 1'b0});
        for (n = 0; n < 3000 && int_reset !== 1'b0; n++) begin
            @(negedge mclk);
            if (reset_in_oe === 1'b1 && reset_in_n === 1'b0) seen = 1'b1;
        end
        check("bidir_drive", seen, m);
        check("syscfg_clr", syscfg, 16'h0000);
        u_far.set_mode(1'b1);
        wait_run(n);
        $display("done bidir %0d", m);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        t_por();
        t_ext_boot();
        u_far.set_mode(1'b1);
        t_wdt();
        t_div();
        t_cmds();
        t_hw(60, 1'b0);
        t_hw(400, 1'b0);
        t_hw(700, 1'b1);
        t_async_mid();
        t_bidir(1'b1);
        t_bidir(1'b0);
        tally_and_finish();
    end
endmodule
